/* File: common/lsc_pkg.sv */
`default_nettype none
package lsc_pkg;
   // ***************************************
   // clock and time base
   // ***************************************
   localparam int CLK_NS       = 10;     // sys_clk period
   localparam int TICK_NS      = 1000;   // hiccup time base, 1 us
   localparam int TICK_CYC     = TICK_NS / CLK_NS;
   localparam int TICKS_PER_MS = 1000000 / TICK_NS;
   // ***************************************
   // hiccup phase times
   // ***************************************
   localparam int ON_SHORT_MS  = 4;
   localparam int OFF_SHORT_MS = 128;
   localparam int ON_LONG_MS   = 8;
   localparam int OFF_LONG_MS  = 256;
   // ***************************************
   // tone timing
   // ***************************************
   localparam int TONE_HZ       = 22000;
   localparam int TONE_PER_CYC  = 1000000000 / (TONE_HZ * CLK_NS);
   localparam int TONE_HALF_CYC = TONE_PER_CYC / 2;
   localparam int FAST_HALF_CYC = (TONE_HALF_CYC * 3) / 4;
   // ***************************************
   // register map
   // ***************************************
   localparam logic [7:0] ADR_MODE = 8'h00; // tone source select
   localparam logic [7:0] ADR_CTRL = 8'h01; // first control register
   localparam logic [7:0] ADR_STAT = 8'h02; // second control / status
   localparam int MODE_INT_B = 0;  // 1: internal tone generator
   localparam int CTRL_HIC_B = 0;  // 1: 8 ms on / 256 ms off
   localparam int CTRL_E44_B = 1;  // external_tone_44k_select
   localparam int CTRL_RCS_B = 7;  // register_control_select
   localparam int STAT_VG_B  = 0;  // output_voltage_good
   localparam int STAT_FLT_B = 1;  // latched fault
   localparam int STAT_OCP_B = 2;  // hiccup in progress
   localparam int STAT_OTP_B = 3;  // thermal shutdown
   localparam int STAT_TD_B  = 4;  // tone detected
   localparam int STAT_EN_B  = 5;  // register enable bit
   localparam int STAT_DOM_B = 6;  // detect_output_mode
   localparam logic [7:0] MODE_RST = 8'h01;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic       EN_RST   = 1'b1;
   localparam logic       DOM_RST  = 1'b0;
   // ***************************************
   // types
   // ***************************************
   typedef struct packed {
      logic en_pin;           // enable pin
      logic tone_gate_input;  // tone gate / external tone
      logic det_in;           // squared tone detect input
      logic ocp;              // overcurrent / short indication
      logic ovt_hi;           // junction above upper threshold
      logic ovt_lo;           // junction below lower threshold
      logic vgood;            // output_voltage_good comparator
   } lsc_pins_s;
   typedef enum logic [1:0] {HIC_IDLE, HIC_CLAMP, HIC_OFF} lsc_hic_e;
endpackage
`default_nettype wire

/* File: design/lsc_top.sv */
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - hold clamped output 4 ms first
// - persisting fault: off 128 ms, retry
// - hiccup times chosen by register bit
// - pairs 4/128 ms or 8/256 ms
// - thermal off at high, on at low
// - registers answer during any protection
// - fault pin low, latched, on protection
// - enable pin recycle releases fault
// - status read releases fault under registers
// - internal tone gated by gate level
// - external tone passed from gate input
// - 44k select passes 44 kHz tone
// - detect tone, open-drain report
// - default mode: low while tone present
// - detect within one and half periods
// - pin control: enable follows pin
// - registers reachable whatever pin level
// - register select: enable bit governs
// - register select resets to zero
// - voltage good in status bit 0
// - select bit is bit 7 at 0x01
// - register enable bit resets to one
module lsc_top #(
   parameter int ON_SHORT_T  = lsc_pkg::ON_SHORT_MS * lsc_pkg::TICKS_PER_MS,
   parameter int OFF_SHORT_T = lsc_pkg::OFF_SHORT_MS * lsc_pkg::TICKS_PER_MS,
   parameter int ON_LONG_T   = lsc_pkg::ON_LONG_MS * lsc_pkg::TICKS_PER_MS,
   parameter int OFF_LONG_T  = lsc_pkg::OFF_LONG_MS * lsc_pkg::TICKS_PER_MS,
   parameter int PH_W        = 18
) (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire lsc_pkg::lsc_pins_s pins,
   input  wire logic [7:0]        addr,
   input  wire logic [7:0]        wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic [7:0]             rdata,
   output logic                   supply_on,
   output logic                   converter_on,
   output logic                   tone_out,
   output logic                   fault_o,
   output logic                   fault_oe_n,
   output logic                   detect_o,
   output logic                   detect_oe_n
);
   import lsc_pkg::*;

   // ***************************************
   // parameter checks
   // ***************************************
   if (ON_SHORT_T < 1 || OFF_SHORT_T < 1 || ON_LONG_T < 1 || OFF_LONG_T < 1) begin : g_bad_t
      $error("hiccup phase lengths must be at least one tick");
   end
   if (OFF_LONG_T >= (1 << PH_W) || ON_LONG_T >= (1 << PH_W)) begin : g_bad_w
      $error("PH_W too narrow for hiccup phase lengths");
   end

   // sized forms of the phase lengths
   localparam logic [PH_W-1:0] ON_S  = PH_W'(ON_SHORT_T - 1);
   localparam logic [PH_W-1:0] OFF_S = PH_W'(OFF_SHORT_T - 1);
   localparam logic [PH_W-1:0] ON_L  = PH_W'(ON_LONG_T - 1);
   localparam logic [PH_W-1:0] OFF_L = PH_W'(OFF_LONG_T - 1);
   localparam logic [6:0]  TICK_END = 7'(TICK_CYC - 1);
   localparam logic [12:0] HALF_END = 13'(TONE_HALF_CYC - 1);
   localparam logic [12:0] FAST_LIM = 13'(FAST_HALF_CYC);
   localparam logic [12:0] DET_LIM  = 13'(TONE_PER_CYC);

   // ***************************************
   // pin synchronisers
   // ***************************************
   lsc_pins_s meta_r;   // first stage, read only by stage two
   lsc_pins_s pin_r;    // safe copy for all logic
   logic      en_d_r;   // previous enable pin level
   logic      gate_d_r; // previous gate level
   logic      det_d_r;  // previous detect input level

   // two flops on every pin input
   always_ff @(posedge sys_clk) begin
      meta_r <= pins;
      pin_r  <= meta_r;
   end

   // edge history of the safe copies
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         en_d_r   <= 1'b1; // idle high, so no false rise after reset
         gate_d_r <= 1'b0;
         det_d_r  <= 1'b0;
      end else begin
         en_d_r   <= pin_r.en_pin;
         gate_d_r <= pin_r.tone_gate_input;
         det_d_r  <= pin_r.det_in;
      end
   end

   wire en_rise   = pin_r.en_pin & ~en_d_r;
   wire gate_rise = pin_r.tone_gate_input & ~gate_d_r;
   wire gate_edge = pin_r.tone_gate_input ^ gate_d_r;
   wire det_edge  = pin_r.det_in ^ det_d_r;

   // ***************************************
   // register file
   // ***************************************
   // the bus never looks at the enable pin or the
   // protection state, so it stays live throughout
   logic [7:0] mode_r;  // tone source
   logic [7:0] ctrl_r;  // select, hiccup, 44k
   logic       en_r;    // register output enable
   logic       dom_r;   // detect_output_mode

   wire wr_mode = wr & (addr == ADR_MODE);
   wire wr_ctrl = wr & (addr == ADR_CTRL);
   wire wr_stat = wr & (addr == ADR_STAT);
   wire rd_stat = rd & (addr == ADR_STAT);

   // plain stores, no side effects on write
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_r <= MODE_RST;
         ctrl_r <= CTRL_RST;
         en_r   <= EN_RST;
         dom_r  <= DOM_RST;
      end else begin
         if (wr_mode) begin
            mode_r <= wdata;
         end
         if (wr_ctrl) begin
            ctrl_r <= wdata;
         end
         if (wr_stat) begin
            en_r  <= wdata[STAT_EN_B];
            dom_r <= wdata[STAT_DOM_B]; // kept in case software errs
         end
      end
   end

   wire rcs      = ctrl_r[CTRL_RCS_B];
   wire hic_long = ctrl_r[CTRL_HIC_B];
   wire e44      = ctrl_r[CTRL_E44_B];
   wire int_tone = mode_r[MODE_INT_B];

   // ***************************************
   // hiccup time base
   // ***************************************
   logic [6:0] tick_cnt_r; // cycles within one tick
   wire        tick = (tick_cnt_r == TICK_END);

   // free running, so phases need no prescaler reset
   always_ff @(posedge sys_clk) begin
      if (rst || tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 7'h01;
      end
   end

   // ***************************************
   // hiccup sequencer
   // ***************************************
   lsc_hic_e        hic_r, hic_nxt;
   logic [PH_W-1:0] ph_cnt_r, ph_cnt_nxt;
   // phase ends; limits picked by the timing bit
   wire [PH_W-1:0]  on_end  = hic_long ? ON_L : ON_S;
   wire [PH_W-1:0]  off_end = hic_long ? OFF_L : OFF_S;
   wire             ph_done_on  = tick & (ph_cnt_r >= on_end);
   wire             ph_done_off = tick & (ph_cnt_r >= off_end);

   // next state; counter restarts on every change
   always_comb begin
      hic_nxt    = hic_r;
      ph_cnt_nxt = tick ? ph_cnt_r + PH_W'(1) : ph_cnt_r;
      case (hic_r)
         HIC_IDLE: begin
            ph_cnt_nxt = '0;
            if (pin_r.ocp) begin
               hic_nxt = HIC_CLAMP; // clamp first
            end
         end
         HIC_CLAMP: begin
            if (!pin_r.ocp) begin
               hic_nxt    = HIC_IDLE;
               ph_cnt_nxt = '0;
            end else if (ph_done_on) begin
               hic_nxt    = HIC_OFF;
               ph_cnt_nxt = '0;
            end
         end
         HIC_OFF: begin
            if (ph_done_off) begin
               hic_nxt    = HIC_IDLE; // restart, retries if still shorted
               ph_cnt_nxt = '0;
            end
         end
         default: begin
            hic_nxt    = HIC_IDLE;
            ph_cnt_nxt = '0;
         end
      endcase
   end

   // state registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hic_r    <= HIC_IDLE;
         ph_cnt_r <= '0;
      end else begin
         hic_r    <= hic_nxt;
         ph_cnt_r <= ph_cnt_nxt;
      end
   end

   // ***************************************
   // thermal shutdown
   // ***************************************
   logic otp_r; // output held off for heat

   // hysteresis between the two thresholds
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         otp_r <= 1'b0;
      end else if (pin_r.ovt_hi) begin
         otp_r <= 1'b1;
      end else if (pin_r.ovt_lo) begin
         otp_r <= 1'b0;
      end
   end

   // ***************************************
   // latched fault
   // ***************************************
   logic fault_r;
   wire  ocp_enter = (hic_r == HIC_IDLE) & pin_r.ocp;
   wire  flt_set   = ocp_enter | pin_r.ovt_hi;
   wire  flt_clr   = rcs ? rd_stat : en_rise;

   // set wins when both land together
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fault_r <= 1'b0;
      end else if (flt_set) begin
         fault_r <= 1'b1;
      end else if (flt_clr) begin
         fault_r <= 1'b0;
      end
   end

   // ***************************************
   // output enable
   // ***************************************
   wire want_on = rcs ? en_r : pin_r.en_pin;
   wire hic_off = (hic_r == HIC_OFF);
   wire on_nxt  = want_on & ~otp_r & ~hic_off;

   // registered drive of the regulator enables
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         supply_on    <= 1'b0;
         converter_on <= 1'b0;
      end else begin
         supply_on    <= on_nxt;                 // stays on in clamp
         converter_on <= on_nxt;
      end
   end

   // ***************************************
   // internal 22 kHz generator
   // ***************************************
   logic [12:0] osc_cnt_r; // half period counter
   logic        osc_r;     // square wave

   // free running square wave
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         osc_cnt_r <= '0;
         osc_r     <= 1'b0;
      end else if (osc_cnt_r == HALF_END) begin
         osc_cnt_r <= '0;
         osc_r     <= ~osc_r;
      end else begin
         osc_cnt_r <= osc_cnt_r + 13'h0001;
      end
   end

   // ***************************************
   // external tone rate check
   // ***************************************
   // a 44 kHz input has half periods well below the
   // 22 kHz ones; without the select bit it is halved
   logic [12:0] ext_cnt_r; // cycles since last gate edge
   logic        fast_r;    // input judged 44 kHz
   logic        div_r;     // halved external tone

   // measure each half period of the gate input
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ext_cnt_r <= '0;
         fast_r    <= 1'b0;
      end else if (gate_edge) begin
         ext_cnt_r <= '0;
         fast_r    <= (ext_cnt_r < FAST_LIM);
      end else if (ext_cnt_r != DET_LIM) begin
         ext_cnt_r <= ext_cnt_r + 13'h0001;
      end
   end

   // divide by two on rising edges
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_r <= 1'b0;
      end else if (gate_rise) begin
         div_r <= ~div_r;
      end
   end

   // ***************************************
   // tone gating
   // ***************************************
   wire ext_tone = (fast_r & ~e44) ? div_r
                                   : pin_r.tone_gate_input;
   wire int_gate = pin_r.tone_gate_input & osc_r;
   wire tone_nxt = supply_on & (int_tone ? int_gate : ext_tone);

   // tone drive registered
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tone_out <= 1'b0;
      end else begin
         tone_out <= tone_nxt;
      end
   end

   // ***************************************
   // tone detector
   // ***************************************
   // present from the first edge; absent after one
   // full tone period without an edge, which keeps
   // the lag under one and a half periods
   logic [12:0] det_cnt_r; // cycles since last input edge
   logic        tone_r;    // tone present

   // edge watchdog
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         det_cnt_r <= '0;
         tone_r    <= 1'b0;
      end else if (det_edge) begin
         det_cnt_r <= '0;
         tone_r    <= 1'b1;
      end else if (det_cnt_r == DET_LIM) begin
         tone_r    <= 1'b0;
      end else begin
         det_cnt_r <= det_cnt_r + 13'h0001;
      end
   end

   // open-drain drive of the detect and fault pins
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         detect_oe_n <= 1'b1;
         fault_oe_n  <= 1'b1;
      end else begin
         detect_oe_n <= ~(tone_r ^ dom_r); // pull low on tone while dom_r is 0, on no tone while 1
         fault_oe_n  <= ~fault_r;
      end
   end

   assign detect_o = 1'b0; // open drain only pulls low
   assign fault_o  = 1'b0;

   // ***************************************
   // read path
   // ***************************************
   wire [7:0] stat_val = {1'b0, dom_r, en_r, tone_r, otp_r,
                          (hic_r != HIC_IDLE), fault_r,
                          pin_r.vgood};
   wire [7:0] rd_mux = (addr == ADR_MODE) ? mode_r :
                       (addr == ADR_CTRL) ? ctrl_r :
                       (addr == ADR_STAT) ? stat_val : 8'h00;

   // data in the cycle after the strobe only
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         rdata <= rd_mux;
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

/* File: test/lsc_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ***************************************
// port checker for the supply control block
// ***************************************
module lsc_top_chk
   import lsc_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire lsc_pkg::lsc_pins_s pins,
   input  wire logic [7:0]        addr,
   input  wire logic              rd,
   input  wire logic [7:0]        rdata,
   input  wire logic              supply_on,
   input  wire logic              converter_on,
   input  wire logic              fault_o,
   input  wire logic              fault_oe_n,
   input  wire logic              detect_o,
   input  wire logic              detect_oe_n
);
   // one domain, so clock and reset are declared once
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // read data only in the answer cycle
   a_read_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data seen outside answer cycle");
   // holes in the map read as zero
   a_unmapped_read: assert property (rd && addr > ADR_STAT |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   // boost and regulator switch together
   a_converter_pair: assert property (converter_on == supply_on)
      else $error("converter and regulator disagree");
   // open-drain pins only ever pull low
   a_pin_data_low: assert property (!fault_o && !detect_o)
      else $error("open-drain data not low");
   // over-temperature cuts supply within sync latency
   a_thermal_cut: assert property (pins.ovt_hi [*6] |-> !supply_on)
      else $error("supply on during over-temperature");
   // over-temperature latches the fault pin
   a_thermal_fault: assert property (pins.ovt_hi [*6] |-> !fault_oe_n)
      else $error("fault pin not pulled on over-temperature");
   // overcurrent pulls the fault pin quickly
   a_ocp_fault: assert property ($rose(pins.ocp) ##1 pins.ocp [*4] |-> !fault_oe_n)
      else $error("fault pin not pulled on overcurrent");
   // clamp phase keeps the regulator running
   a_clamp_keeps: assert property ($rose(pins.ocp) && supply_on |=> supply_on [*8])
      else $error("supply dropped at clamp start");
   // first tone edge pulls the detect pin
   a_detect_pull: assert property ($rose(pins.det_in) |-> ##[1:6] !detect_oe_n)
      else $error("detect pin not pulled on tone edge");
endmodule
bind lsc_top lsc_top_chk u_chk (
   .sys_clk(sys_clk), .rst(rst), .pins(pins), .addr(addr), .rd(rd), .rdata(rdata),
   .supply_on(supply_on), .converter_on(converter_on), .fault_o(fault_o),
   .fault_oe_n(fault_oe_n), .detect_o(detect_o), .detect_oe_n(detect_oe_n)
);
`default_nettype wire

/* File: test/lsc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ***************************************
// host processor and analog side model
// ***************************************
module lsc_host
   import lsc_pkg::*;
(
   input  wire logic              sys_clk,
   output var lsc_pkg::lsc_pins_s pins,
   output logic [7:0]             addr,
   output logic [7:0]             wdata,
   output logic                   wr,
   output logic                   rd,
   input  wire logic [7:0]        rdata
);
   int gate_half = 0; // external tone half period, 0 = level mode
   int det_half  = 0; // detect tone half period, 0 = quiet
   int gcnt      = 0; // gate toggle counter
   int dcnt      = 0; // detect toggle counter
   // enable high, cool, voltage good, no tone
   initial begin
      pins  = 7'h43;
      addr  = 8'h00;
      wdata = 8'h00;
      wr    = 1'b0;
      rd    = 1'b0;
   end
   // square wave sources, free running while enabled
   always @(posedge sys_clk) begin
      if (gate_half > 0) begin
         gcnt <= (gcnt >= gate_half - 1) ? 0 : gcnt + 1;
         if (gcnt >= gate_half - 1) pins.tone_gate_input <= ~pins.tone_gate_input;
      end
      if (det_half > 0) begin
         dcnt <= (dcnt >= det_half - 1) ? 0 : dcnt + 1;
         if (dcnt >= det_half - 1) pins.det_in <= ~pins.det_in;
      end
   end
   // one-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe, so sample mid-cycle
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(negedge sys_clk);
      d = rdata;
   endtask
   // mode bit inverts the detect pin: always written at its default
   task automatic set_en_bit(input logic b);
      wr_reg(ADR_STAT, {1'b0, DOM_RST, b, 5'h00});
   endtask
   // low then high on the enable pin releases the fault
   task automatic recycle_en();
      pins.en_pin <= 1'b0;
      repeat (6) @(posedge sys_clk);
      pins.en_pin <= 1'b1;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
endmodule
`default_nettype wire

/* File: test/lsc_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
   $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
// ***************************************
// self-checking bench
// ***************************************
module lsc_top_bench;
   import lsc_pkg::*;
   logic               sys_clk;         // 100 MHz
   logic               rst;             // synchronous, active high
   lsc_pins_s          pins;            // from the host model
   logic [7:0]         addr, wdata, rdata;
   logic               wr, rd, supply_on, converter_on, tone_out;
   logic               fault_o, fault_oe_n, detect_o, detect_oe_n;
   int                 n_fail = 0;      // mismatches
   int                 checks_done = 0; // comparisons
   int                 cycles = 0;      // hang guard
   logic [7:0]         d;
   int                 n;
   // short phase counts keep the run brief
   lsc_top #(.ON_SHORT_T(4), .OFF_SHORT_T(16), .ON_LONG_T(8), .OFF_LONG_T(32)) dut (
      .sys_clk(sys_clk), .rst(rst), .pins(pins), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .supply_on(supply_on), .converter_on(converter_on),
      .tone_out(tone_out), .fault_o(fault_o), .fault_oe_n(fault_oe_n),
      .detect_o(detect_o), .detect_oe_n(detect_oe_n));
   lsc_host h (.sys_clk(sys_clk), .pins(pins), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // timeout well above the expected run of about 45k cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 90000) begin
         n_fail++;
         results();
      end
   end
   task automatic results();
      if (n_fail == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // waits mid-cycle so every output has settled
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task automatic count_until(ref logic s, input logic v, output int c);
      c = 0;
      while (s !== v && c < 20000) begin
         @(negedge sys_clk);
         c++;
      end
   endtask
   // skip a possibly partial first pulse, then time one high half
   task automatic half_of(output int c);
      for (int i = 0; i < 5; i++) count_until(tone_out, i[0], c);
   endtask
   // one hiccup round; regs selects the status-read release
   task automatic hiccup(input int on_c, input int off_c, input logic regs);
      int t0; // cycle at which the clamp became visible
      h.pins.ocp <= 1'b1;
      count_until(fault_oe_n, 1'b0, n);
      t0 = cycles;
      `CHK("clamp supply", 1'b1, supply_on)
      h.rd_reg(ADR_STAT, d);
      `CHK("hiccup flag", 1'b1, d[STAT_OCP_B])
      cyc(2);
      `CHK("fault after read", regs, fault_oe_n)
      count_until(supply_on, 1'b0, n);
      n = cycles - t0;
      `CHK("on phase", 1'b1, n > on_c - TICK_CYC && n < on_c + TICK_CYC)
      `CHK("converter off", 1'b0, converter_on)
      count_until(supply_on, 1'b1, n);
      `CHK("off phase", 1'b1, n > off_c - TICK_CYC && n < off_c + TICK_CYC)
      h.pins.ocp <= 1'b0;
      cyc(20);
      if (regs) h.rd_reg(ADR_STAT, d);
      else h.recycle_en();
      cyc(2);
      `CHK("fault released", 1'b1, fault_oe_n)
   endtask
   initial begin
      rst = 1'b1;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      cyc(1);
      `CHK("fault idle", 1'b1, fault_oe_n)
      h.rd_reg(ADR_MODE, d);
      `CHK("mode reset", MODE_RST, d)
      h.rd_reg(ADR_CTRL, d);
      `CHK("ctrl reset", CTRL_RST, d)
      h.rd_reg(ADR_STAT, d);
      `CHK("status reset", 8'h21, d)
      h.rd_reg(8'h07, d);
      `CHK("unmapped", 8'h00, d)
      h.pins.en_pin <= 1'b0;
      cyc(8);
      `CHK("pin off", 1'b0, supply_on)
      h.wr_reg(ADR_CTRL, 8'h80);
      cyc(3);
      `CHK("register on", 1'b1, supply_on)
      h.set_en_bit(1'b0);
      cyc(3);
      `CHK("register off", 1'b0, supply_on)
      h.set_en_bit(1'b1);
      h.wr_reg(ADR_CTRL, 8'h00);
      h.pins.en_pin <= 1'b1;
      cyc(8);
      `CHK("pin on", 1'b1, supply_on)
      hiccup(4 * TICK_CYC, 16 * TICK_CYC, 1'b0); // short pair, pin release
      h.wr_reg(ADR_CTRL, 8'h81);
      hiccup(8 * TICK_CYC, 32 * TICK_CYC, 1'b1); // long pair, read release
      h.wr_reg(ADR_CTRL, 8'h00);
      h.pins.ovt_hi <= 1'b1;
      h.pins.ovt_lo <= 1'b0;
      cyc(8);
      `CHK("thermal off", 1'b0, supply_on)
      h.pins.ovt_hi <= 1'b0;
      h.pins.vgood  <= 1'b0;
      cyc(8);
      `CHK("hysteresis", 1'b0, supply_on)
      h.rd_reg(ADR_STAT, d);
      `CHK("thermal flag", 1'b1, d[STAT_OTP_B])
      `CHK("voltage good low", 1'b0, d[STAT_VG_B])
      h.pins.ovt_lo <= 1'b1;
      h.pins.vgood  <= 1'b1;
      cyc(8);
      `CHK("thermal on", 1'b1, supply_on)
      h.recycle_en();
      `CHK("thermal release", 1'b1, fault_oe_n)
      h.pins.tone_gate_input <= 1'b1;
      half_of(n);
      `CHK("internal tone", 1'b1, n > TONE_HALF_CYC - 3 && n < TONE_HALF_CYC + 3)
      h.pins.tone_gate_input <= 1'b0;
      cyc(6);
      `CHK("tone gated", 1'b0, tone_out)
      h.wr_reg(ADR_MODE, 8'h00);
      h.gate_half = TONE_HALF_CYC;
      half_of(n);
      `CHK("external tone", 1'b1, n > TONE_HALF_CYC - 3 && n < TONE_HALF_CYC + 3)
      h.gate_half = TONE_HALF_CYC / 2;
      half_of(n);
      `CHK("44k default", 1'b1, n > TONE_HALF_CYC - 4 && n < TONE_HALF_CYC + 4)
      h.wr_reg(ADR_CTRL, 8'h02);
      half_of(n);
      `CHK("44k pass", 1'b1, n > TONE_HALF_CYC / 2 - 3 && n < TONE_HALF_CYC / 2 + 3)
      h.gate_half = 0;
      h.det_half = TONE_HALF_CYC;
      count_until(detect_oe_n, 1'b0, n);
      `CHK("detect pull", 1'b1, n <= 3 * TONE_HALF_CYC)
      h.det_half = 0;
      count_until(detect_oe_n, 1'b1, n);
      `CHK("detect release", 1'b1, n <= 3 * TONE_HALF_CYC)
      results();
   end
endmodule
`default_nettype wire
